//--- design/ssp_defines.vh
`ifndef SSP_DEFINES_VH
`define SSP_DEFINES_VH
// Register byte offsets.
`define SSP_CTRL_OFS 4'h0
`define SSP_STRAP_OFS 4'h4
`define SSP_LIVE_OFS 4'h8
// Control register fields.
`define SSP_CTRL_STS_EN 0
`define SSP_CTRL_AUTO_DIS 1
`define SSP_CTRL_RST 32'h00000000
// Strap register fields (read only).
`define SSP_STRAP_GANG 0
`define SSP_STRAP_AUTO 1
`define SSP_STRAP_IFSEL 2
`define SSP_STRAP_PWRMGMT 3
`define SSP_STRAP_VALID 4
// Live status register fields (read only).
`define SSP_LIVE_PERPORT 0
`define SSP_LIVE_GANGED 1
`define SSP_LIVE_SMBUS 2
`define SSP_LIVE_ADDR2 3
`define SSP_LIVE_AUTOACT 4
`define SSP_LIVE_CDP1_BLOCK 5
`define SSP_LIVE_PWRSW 6
// AXI responses.
`define SSP_RESP_OKAY 2'h0
`define SSP_RESP_SLVERR 2'h2
`endif

//--- design/ssp_strap_latch.v
`timescale 1ns/1ns
`default_nettype none
module ssp_strap_latch (
   input wire aclk,
   input wire aresetn,
   input wire pin_in,
   output reg strap_value,
   output reg strap_valid
);
   // Capture on the first clock after release, so reset itself only loads constants.
   always @(posedge aclk) begin
      if (!aresetn) begin
         strap_value <= 1'b0;
         strap_valid <= 1'b0;
      end else if (!strap_valid) begin
         strap_value <= pin_in;
         strap_valid <= 1'b1;
      end
   end
endmodule // ssp_strap_latch
`default_nettype wire

//--- design/ssp_strap_pins.v
// Functional notes
// - At reset release the gang strap is latched: low means per-port and high ganged power, only with switching on.
// - In SMBus mode the latched gang strap level is used as slave address bit 2.
// - After reset with status output enabled the gang pin shows upstream high-speed connection.
// - At reset release the auto charge strap is latched: low enables auto charge while unconnected, high disables it.
// - While auto charge mode is active, CDP is not offered on downstream port 1.
// - The latched auto charge level is copied into the auto-mode-disable bit at reset release.
// - After reset with status output enabled the auto charge pin shows upstream high-speed suspend.
// - At reset release the interface strap is latched: high is I2C and low is SMBus.
// - At reset release the power management strap is latched: low enables power switching and over-current; no over-current logic in the code.
//
// Added by the designer: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "ssp_defines.vh"
module ssp_strap_pins (
   input wire aclk,
   input wire aresetn,
   input wire [3:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [3:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   input wire gang_pin_in,
   output reg gang_pin_out,
   output reg gang_pin_oe,
   input wire auto_pin_in,
   output reg auto_pin_out,
   output reg auto_pin_oe,
   input wire interface_select_strap,
   input wire power_management_strap,
   input wire upstream_highspeed_connected,
   input wire upstream_highspeed_suspended,
   input wire hub_upstream_connected,
   output reg per_port_power,
   output reg ganged_power,
   output reg power_switching_enabled,
   output reg smbus_mode,
   output reg slave_addr_bit2,
   output reg auto_charge_active,
   output reg cdp_port1_blocked
);
   wire [3:0] strap_val;
   wire [3:0] strap_vld;
   wire [3:0] strap_pins;
   wire straps_done;
   wire gang_strap;
   wire auto_charge_strap;
   wire ifsel_strap;
   wire pwrmgmt_strap;
   reg status_output_enable;
   reg auto_charge_disable_bit;
   reg copied_reg;
   reg [3:0] aw_addr_reg;
   reg aw_have_reg;
   reg [31:0] w_data_reg;
   reg [3:0] w_strb_reg;
   reg w_have_reg;
   reg [31:0] rd_word;
   reg [31:0] live_word;

   assign strap_pins = {power_management_strap, interface_select_strap, auto_pin_in, gang_pin_in};

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi = gi + 1) begin : g_strap
         ssp_strap_latch u_latch (
            .aclk(aclk),
            .aresetn(aresetn),
            .pin_in(strap_pins[gi]),
            .strap_value(strap_val[gi]),
            .strap_valid(strap_vld[gi])
         );
      end
   endgenerate

   assign straps_done = &strap_vld;
   assign gang_strap = strap_val[0];
   assign auto_charge_strap = strap_val[1];
   assign ifsel_strap = strap_val[2];
   assign pwrmgmt_strap = strap_val[3];

   // Each write channel is accepted only while it holds no beat of its own and no response waits, so one write is in flight at a time.
   assign s_axi_awready = !aw_have_reg && !s_axi_bvalid;
   assign s_axi_wready = !w_have_reg && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;

   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_reg <= 1'b0;
         aw_addr_reg <= 4'h0;
         w_have_reg <= 1'b0;
         w_data_reg <= 32'h00000000;
         w_strb_reg <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `SSP_RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
         end
         if (aw_have_reg && w_have_reg) begin
            aw_have_reg <= 1'b0;
            w_have_reg <= 1'b0;
            s_axi_bvalid <= 1'b1;
            if (aw_addr_reg == `SSP_CTRL_OFS) begin
               s_axi_bresp <= `SSP_RESP_OKAY;
            end else if (aw_addr_reg == `SSP_STRAP_OFS || aw_addr_reg == `SSP_LIVE_OFS) begin
               s_axi_bresp <= `SSP_RESP_OKAY;
            end else begin
               s_axi_bresp <= `SSP_RESP_SLVERR;
            end
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Software may override the disable bit after the strap copy; the copy happens once per reset.
   always @(posedge aclk) begin
      if (!aresetn) begin
         status_output_enable <= 1'b0;
         auto_charge_disable_bit <= 1'b0;
         copied_reg <= 1'b0;
      end else begin
         if (straps_done && !copied_reg) begin
            copied_reg <= 1'b1;
            auto_charge_disable_bit <= auto_charge_strap;
         end else if (aw_have_reg && w_have_reg && aw_addr_reg == `SSP_CTRL_OFS && w_strb_reg[0]) begin
            auto_charge_disable_bit <= w_data_reg[`SSP_CTRL_AUTO_DIS];
         end
         if (aw_have_reg && w_have_reg && aw_addr_reg == `SSP_CTRL_OFS && w_strb_reg[0]) begin
            status_output_enable <= w_data_reg[`SSP_CTRL_STS_EN];
         end
      end
   end

   always @* begin
      live_word = 32'h00000000;
      live_word[`SSP_LIVE_PERPORT] = per_port_power;
      live_word[`SSP_LIVE_GANGED] = ganged_power;
      live_word[`SSP_LIVE_SMBUS] = smbus_mode;
      live_word[`SSP_LIVE_ADDR2] = slave_addr_bit2;
      live_word[`SSP_LIVE_AUTOACT] = auto_charge_active;
      live_word[`SSP_LIVE_CDP1_BLOCK] = cdp_port1_blocked;
      live_word[`SSP_LIVE_PWRSW] = power_switching_enabled;
      rd_word = 32'h00000000;
      case (s_axi_araddr)
         `SSP_CTRL_OFS: begin
            rd_word[`SSP_CTRL_STS_EN] = status_output_enable;
            rd_word[`SSP_CTRL_AUTO_DIS] = auto_charge_disable_bit;
         end
         `SSP_STRAP_OFS: begin
            rd_word[`SSP_STRAP_GANG] = gang_strap;
            rd_word[`SSP_STRAP_AUTO] = auto_charge_strap;
            rd_word[`SSP_STRAP_IFSEL] = ifsel_strap;
            rd_word[`SSP_STRAP_PWRMGMT] = pwrmgmt_strap;
            rd_word[`SSP_STRAP_VALID] = straps_done;
         end
         `SSP_LIVE_OFS: begin
            rd_word = live_word;
         end
         default: begin
            rd_word = 32'h00000000;
         end
      endcase
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `SSP_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_word;
         if (s_axi_araddr == `SSP_CTRL_OFS || s_axi_araddr == `SSP_STRAP_OFS || s_axi_araddr == `SSP_LIVE_OFS) begin
            s_axi_rresp <= `SSP_RESP_OKAY;
         end else begin
            s_axi_rresp <= `SSP_RESP_SLVERR;
         end
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // Decoded settings; all idle until every strap has been captured.
   always @(posedge aclk) begin
      if (!aresetn) begin
         per_port_power <= 1'b0;
         ganged_power <= 1'b0;
         power_switching_enabled <= 1'b0;
         smbus_mode <= 1'b0;
         slave_addr_bit2 <= 1'b0;
         auto_charge_active <= 1'b0;
         cdp_port1_blocked <= 1'b0;
         gang_pin_out <= 1'b0;
         gang_pin_oe <= 1'b0;
         auto_pin_out <= 1'b0;
         auto_pin_oe <= 1'b0;
      end else begin
         power_switching_enabled <= straps_done && !pwrmgmt_strap;
         per_port_power <= straps_done && !pwrmgmt_strap && !gang_strap;
         ganged_power <= straps_done && !pwrmgmt_strap && gang_strap;
         smbus_mode <= straps_done && !ifsel_strap;
         slave_addr_bit2 <= straps_done && !ifsel_strap && gang_strap;
         auto_charge_active <= copied_reg && !auto_charge_disable_bit && !hub_upstream_connected;
         cdp_port1_blocked <= copied_reg && !auto_charge_disable_bit && !hub_upstream_connected;
         gang_pin_oe <= straps_done && status_output_enable;
         auto_pin_oe <= straps_done && status_output_enable;
         gang_pin_out <= straps_done && status_output_enable && upstream_highspeed_connected;
         auto_pin_out <= straps_done && status_output_enable && upstream_highspeed_suspended;
      end
   end
endmodule // ssp_strap_pins
`default_nettype wire

//--- bench/ssp_board.sv
`timescale 1ns/1ns
`default_nettype none
// The strap resistors hold each pin whenever the hub is not driving it.
module ssp_board (
   input wire logic strap_gang,
   input wire logic strap_auto,
   input wire logic gang_out,
   input wire logic gang_oe,
   input wire logic auto_out,
   input wire logic auto_oe,
   output logic gang_wire,
   output logic auto_wire
);
   assign gang_wire = gang_oe ? gang_out : strap_gang;
   assign auto_wire = auto_oe ? auto_out : strap_auto;
endmodule // ssp_board
`default_nettype wire

//--- bench/ssp_strap_pins_checker.sv
`timescale 1ns/1ns
`default_nettype none
module ssp_strap_pins_checker (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic gang_pin_in,
   input wire logic gang_pin_out,
   input wire logic gang_pin_oe,
   input wire logic auto_pin_in,
   input wire logic auto_pin_out,
   input wire logic auto_pin_oe,
   input wire logic interface_select_strap,
   input wire logic power_management_strap,
   input wire logic upstream_highspeed_connected,
   input wire logic upstream_highspeed_suspended,
   input wire logic hub_upstream_connected,
   input wire logic per_port_power,
   input wire logic ganged_power,
   input wire logic power_switching_enabled,
   input wire logic smbus_mode,
   input wire logic slave_addr_bit2,
   input wire logic auto_charge_active,
   input wire logic cdp_port1_blocked
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence released;
      !aresetn ##1 aresetn;
   endsequence
   // The strap checks look four edges on, so the bench holds straps steady after release.
   chk_oe_at_release: assert property (disable iff (1'b0) released |-> !gang_pin_oe && !auto_pin_oe)
      else $error("pin driven at release");
   chk_gang_latch: assert property (disable iff (1'b0) released |-> ##4
      ganged_power == (gang_pin_in & !power_management_strap)) else $error("gang strap wrong");
   chk_sw_latch: assert property (disable iff (1'b0) released |-> ##4
      power_switching_enabled == !power_management_strap) else $error("switching strap wrong");
   chk_ifsel_latch: assert property (disable iff (1'b0) released |-> ##4
      smbus_mode == !interface_select_strap) else $error("interface strap wrong");
   chk_auto_latch: assert property (disable iff (1'b0) released |-> ##4
      auto_charge_active == (!auto_pin_in & !hub_upstream_connected)) else $error("auto strap wrong");
   chk_addr_mode: assert property (!smbus_mode |-> !slave_addr_bit2) else $error("address bit outside smbus");
   chk_pwr_gate: assert property (ganged_power || per_port_power |-> power_switching_enabled)
      else $error("power mode without switching");
   chk_cdp_block: assert property (cdp_port1_blocked == auto_charge_active) else $error("cdp block wrong");
   chk_gang_status: assert property (gang_pin_oe |-> gang_pin_out == $past(upstream_highspeed_connected))
      else $error("gang status wrong");
   chk_auto_status: assert property (auto_pin_oe |-> auto_pin_out == $past(upstream_highspeed_suspended))
      else $error("suspend status wrong");
   chk_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data not held");
   chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
endmodule // ssp_strap_pins_checker
bind ssp_strap_pins ssp_strap_pins_checker i_chk (.aclk, .aresetn, .s_axi_arvalid, .s_axi_arready,
   .s_axi_rvalid, .s_axi_rready, .gang_pin_in,
   .gang_pin_out, .gang_pin_oe, .auto_pin_in, .auto_pin_out, .auto_pin_oe, .interface_select_strap,
   .power_management_strap, .upstream_highspeed_connected, .upstream_highspeed_suspended, .hub_upstream_connected,
   .per_port_power, .ganged_power, .power_switching_enabled, .smbus_mode, .slave_addr_bit2, .auto_charge_active,
   .cdp_port1_blocked, .s_axi_rdata);
`default_nettype wire

//--- bench/ssp_strap_pins_tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "ssp_defines.vh"
module ssp_strap_pins_tb;
   logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, sg, sa, ifsel, pm, hsc, hss, hub, sw, d;
   logic [3:0] awaddr, araddr, wstrb;
   logic [31:0] wdata, rd, e;
   logic [1:0] rs;
   wire awready, wready, bvalid, arready, rvalid, gi, ai, go, goe, ao, aoe, ppp, gp, psw, smb, ad2, aca, cdp;
   wire [1:0] bresp, rresp;
   wire [31:0] rdata;
   integer err_count = 0, n_compared = 0, seed = 87569, i, k;
   ssp_board i_ssp_board (.strap_gang(sg), .strap_auto(sa), .gang_out(go), .gang_oe(goe), .auto_out(ao),
      .auto_oe(aoe), .gang_wire(gi), .auto_wire(ai));
   ssp_strap_pins i_ssp_strap_pins (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .gang_pin_in(gi), .gang_pin_out(go), .gang_pin_oe(goe),
      .auto_pin_in(ai), .auto_pin_out(ao), .auto_pin_oe(aoe), .interface_select_strap(ifsel),
      .power_management_strap(pm), .upstream_highspeed_connected(hsc), .upstream_highspeed_suspended(hss),
      .hub_upstream_connected(hub), .per_port_power(ppp), .ganged_power(gp), .power_switching_enabled(psw),
      .smbus_mode(smb), .slave_addr_bit2(ad2), .auto_charge_active(aca), .cdp_port1_blocked(cdp));
   initial begin
      aclk = 1'h0;
      forever #50 aclk = ~aclk;
   end
   task tally_and_finish;
      if (err_count == 0 && n_compared > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task chb(input logic got, input logic exp);
      chk({31'h0, got}, {31'h0, exp});
   endtask
   task tmo(input logic f);
      if (f) begin
         err_count++;
         $display("mismatch %0t no answer", $time);
         tally_and_finish;
      end
   endtask
   // Handshakes are judged at the falling edge, which still shows what the next rising edge samples.
   task axw(input logic [3:0] a, input logic [31:0] dt, input logic [3:0] st);
      logic ah, wh, bh;
      @(posedge aclk);
      awaddr <= a;
      wdata <= dt;
      wstrb <= st;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      bh = 1'h0;
      for (k = 0; k < 40 && !bh; k++) begin
         @(negedge aclk);
         ah = awvalid & awready;
         wh = wvalid & wready;
         bh = bvalid;
         rs = bresp;
         @(posedge aclk);
         if (ah) awvalid <= 1'h0;
         if (wh) wvalid <= 1'h0;
         if (bh) bready <= 1'h0;
      end
      tmo(!bh);
   endtask
   task axr(input logic [3:0] a);
      logic ah, rh;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      rh = 1'h0;
      for (k = 0; k < 40 && !rh; k++) begin
         @(negedge aclk);
         ah = arvalid & arready;
         rh = rvalid;
         rd = rdata;
         rs = rresp;
         @(posedge aclk);
         if (ah) arvalid <= 1'h0;
         if (rh) rready <= 1'h0;
      end
      tmo(!rh);
   endtask
   initial begin
      aresetn <= 1'h0;
      {awvalid, wvalid, bready, arvalid, rready, hsc, hss} <= 7'h00;
      {awaddr, araddr, wstrb, wdata} <= 44'h0;
      {sg, sa, ifsel, pm, hub} <= 5'h0;
      for (i = 0; i < 20; i++) begin
         e = (i < 16) ? i * 17 : $random(seed);
         @(posedge aclk);
         aresetn <= 1'h0;
         // Boards that enable auto charge must strap per-port power.
         sg <= e[0] & e[1];
         sa <= e[1];
         ifsel <= e[2];
         pm <= e[3];
         hub <= e[4];
         repeat (3) @(posedge aclk);
         aresetn <= 1'h1;
         repeat (6) @(posedge aclk);
         @(negedge aclk);
         sw = !pm;
         chb(ppp, sw & !sg);
         chb(gp, sw & sg);
         chb(psw, sw);
         chb(smb, !ifsel);
         chb(ad2, !ifsel & sg);
         chb(aca, !sa & !hub);
         chb(cdp, !sa & !hub);
         axr(`SSP_CTRL_OFS);
         chk(rd, {30'h0, sa, 1'h0});
         axr(4'hC);
         chk(rd, 32'h00000000);
         chk({30'h0, rs}, {30'h0, `SSP_RESP_SLVERR});
         e = $random(seed);
         axw(`SSP_STRAP_OFS, e, 4'hF);
         chk({30'h0, rs}, {30'h0, `SSP_RESP_OKAY});
         axr(`SSP_STRAP_OFS);
         chk(rd, {27'h1, pm, ifsel, sa, sg});
         e = $random(seed);
         d = e[0];
         axw(`SSP_CTRL_OFS, {30'h0, d, 1'h1}, 4'h1);
         chk({30'h0, rs}, {30'h0, `SSP_RESP_OKAY});
         // Without byte lane 0 the control register must keep its value.
         axw(`SSP_CTRL_OFS, {30'h0, !d, 1'h0}, 4'hE);
         chk({30'h0, rs}, {30'h0, `SSP_RESP_OKAY});
         axr(`SSP_CTRL_OFS);
         chk(rd, {30'h0, d, 1'h1});
         axr(`SSP_LIVE_OFS);
         chk(rd, {25'h0, sw, !d & !hub, !d & !hub, !ifsel & sg, !ifsel, sw & sg, sw & !sg});
         repeat (4) begin
            @(posedge aclk);
            e = $random(seed);
            hsc <= e[0];
            hss <= e[1];
            hub <= e[2];
            @(posedge aclk);
            @(negedge aclk);
            chk({28'h0, goe, go, aoe, ao}, {28'h0, 1'h1, e[0], 1'h1, e[1]});
            chb(aca, !d & !e[2]);
            chb(cdp, !d & !e[2]);
            chb(smb, !ifsel);
         end
      end
      tally_and_finish;
   end
endmodule // ssp_strap_pins_tb
`default_nettype wire
